// ==== common/tpp_if.sv ====
// the four-wire test link between the scan controller and the device port
// assumes the bench ties it to both ends; undriven lines read as pulled high
`timescale 1ns/1ps
interface tpp_if;
   logic tck_out; // host clock drive
   logic tck_oe; // host drives tck
   logic tms_out;
   logic tms_oe;
   logic tdi_out;
   logic tdi_oe;
   logic tdo_out; // device serial output
   logic tdo_oe; // device drives tdo
   logic tck; // resolved wire levels, pull-ups stand in for the floating case
   logic tms;
   logic tdi;
   logic tdo;
   assign tck = tck_oe ? tck_out : 1'b1;
   assign tms = tms_oe ? tms_out : 1'b1;
   assign tdi = tdi_oe ? tdi_out : 1'b1;
   assign tdo = tdo_oe ? tdo_out : 1'b1;
   modport dev (input tck, input tms, input tdi, output tdo_out, output tdo_oe);
   modport host (output tck_out, output tck_oe, output tms_out, output tms_oe,
      output tdi_out, output tdi_oe, input tdo, input tdo_oe);
endinterface

// ==== common/tpp_pkg.sv ====
// shared constants and types of the test access port and its scan controller
// assumes both ends compile against this package and name it in full
package tpp_pkg;
   // controller states, binary codes written out
   typedef enum logic [3:0] {
      TPP_TLR = 4'h0, // test-logic-reset
      TPP_RTI = 4'h1, // run-test/idle
      TPP_SEL_DR = 4'h2,
      TPP_CAP_DR = 4'h3,
      TPP_SH_DR = 4'h4,
      TPP_EX1_DR = 4'h5,
      TPP_PA_DR = 4'h6,
      TPP_EX2_DR = 4'h7,
      TPP_UP_DR = 4'h8,
      TPP_SEL_IR = 4'h9,
      TPP_CAP_IR = 4'ha,
      TPP_SH_IR = 4'hb,
      TPP_EX1_IR = 4'hc,
      TPP_PA_IR = 4'hd,
      TPP_EX2_IR = 4'he,
      TPP_UP_IR = 4'hf
   } tpp_state_t;
   localparam int TPP_IR_W = 3; // instruction length
   localparam int TPP_ID_W = 32; // identification register length
   localparam int TPP_BSR_W = 8; // boundary register length, plain default
   // instruction codes; only the all-zero one is fixed, the rest are plain picks
   localparam logic [2:0] TPP_I_EXTEST = 3'h0;
   localparam logic [2:0] TPP_I_IDCODE = 3'h1;
   localparam logic [2:0] TPP_I_SAMPLE = 3'h4;
   localparam logic [2:0] TPP_I_BYPASS = 3'h7;
   localparam logic [2:0] TPP_IR_RESET = TPP_I_IDCODE; // value after reset
   localparam logic [1:0] TPP_IR_CAPTURE = 2'h1; // low bits loaded in capture-ir
   // identity value is arbitrary; bit 0 is one as every id code must be
   localparam logic [31:0] TPP_IDCODE_VAL = 32'h0000_0001;
   localparam logic [TPP_BSR_W-1:0] TPP_BSR_RESET = 8'h00;
   localparam int TPP_RESET_TMS_CYCLES = 5; // tms-high edges that force reset
   // host makes tck from its clock: the high half lasts this many cycles, the low half one more
   localparam int TPP_TCK_HALF_NS = 40;
   localparam int TPP_CORE_NS = 10;
   localparam int TPP_TCK_HALF_CYC = TPP_TCK_HALF_NS / TPP_CORE_NS;
endpackage

// ==== core/tpp_dev.sv ====
// test access port of the memory: controller, instruction, bypass, id and
// boundary registers, all on the link clock, with levels crossed to the core
// assumes i_rst is the power-up reset and i_core_clk runs the core side
`timescale 1ns/1ps
module tpp_dev (
   tpp_if.dev lnk,
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [tpp_pkg::TPP_BSR_W-1:0] i_pins, // core pin levels to capture
   output logic o_tap_reset, // controller sits in test-logic-reset
   output logic o_bsr_drive, // extest: pins take boundary values
   output logic [tpp_pkg::TPP_BSR_W-1:0] o_bsr_data // values for the pins
);
   localparam int W = tpp_pkg::TPP_BSR_W;
   tpp_pkg::tpp_state_t st_q; // controller state
   tpp_pkg::tpp_state_t st_d;
   logic [2:0] ir_sh_q; // instruction shift stage
   logic [2:0] ir_q; // current instruction
   logic byp_q; // bypass cell
   logic [31:0] id_q; // identification shift register
   logic [W-1:0] bsr_sh_q; // boundary shift stage
   logic [W-1:0] bsr_up_q; // boundary update stage
   logic [W-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q; // pins into tck domain
   logic sel_bsr; // boundary register chosen by the instruction
   logic sel_id; // id register chosen
   logic ser_out; // output end of the chosen register
   logic tdo_q; // falling-edge output stage
   logic tdo_oe_q;
   logic extest_t; // extest active, tck domain
   logic rst_s1_q, rst_s2_q, rst_s3_q; // crossings into the core domain
   logic ext_s1_q, ext_s2_q, ext_s3_q;
   logic [W-1:0] dat_s1_q, dat_s2_q, dat_s3_q;

   // next state from tms alone; the wire pull-up makes a floating tms a one
   always_comb begin
      st_d = st_q;
      case (st_q)
         tpp_pkg::TPP_TLR: st_d = lnk.tms ? tpp_pkg::TPP_TLR : tpp_pkg::TPP_RTI;
         tpp_pkg::TPP_RTI: st_d = lnk.tms ? tpp_pkg::TPP_SEL_DR : tpp_pkg::TPP_RTI;
         tpp_pkg::TPP_SEL_DR: st_d = lnk.tms ? tpp_pkg::TPP_SEL_IR : tpp_pkg::TPP_CAP_DR;
         tpp_pkg::TPP_CAP_DR: st_d = lnk.tms ? tpp_pkg::TPP_EX1_DR : tpp_pkg::TPP_SH_DR;
         tpp_pkg::TPP_SH_DR: st_d = lnk.tms ? tpp_pkg::TPP_EX1_DR : tpp_pkg::TPP_SH_DR;
         tpp_pkg::TPP_EX1_DR: st_d = lnk.tms ? tpp_pkg::TPP_UP_DR : tpp_pkg::TPP_PA_DR;
         tpp_pkg::TPP_PA_DR: st_d = lnk.tms ? tpp_pkg::TPP_EX2_DR : tpp_pkg::TPP_PA_DR;
         tpp_pkg::TPP_EX2_DR: st_d = lnk.tms ? tpp_pkg::TPP_UP_DR : tpp_pkg::TPP_SH_DR;
         tpp_pkg::TPP_UP_DR: st_d = lnk.tms ? tpp_pkg::TPP_SEL_DR : tpp_pkg::TPP_RTI;
         tpp_pkg::TPP_SEL_IR: st_d = lnk.tms ? tpp_pkg::TPP_TLR : tpp_pkg::TPP_CAP_IR;
         tpp_pkg::TPP_CAP_IR: st_d = lnk.tms ? tpp_pkg::TPP_EX1_IR : tpp_pkg::TPP_SH_IR;
         tpp_pkg::TPP_SH_IR: st_d = lnk.tms ? tpp_pkg::TPP_EX1_IR : tpp_pkg::TPP_SH_IR;
         tpp_pkg::TPP_EX1_IR: st_d = lnk.tms ? tpp_pkg::TPP_UP_IR : tpp_pkg::TPP_PA_IR;
         tpp_pkg::TPP_PA_IR: st_d = lnk.tms ? tpp_pkg::TPP_EX2_IR : tpp_pkg::TPP_PA_IR;
         tpp_pkg::TPP_EX2_IR: st_d = lnk.tms ? tpp_pkg::TPP_UP_IR : tpp_pkg::TPP_SH_IR;
         tpp_pkg::TPP_UP_IR: st_d = lnk.tms ? tpp_pkg::TPP_SEL_DR : tpp_pkg::TPP_RTI;
         default: st_d = tpp_pkg::TPP_TLR;
      endcase
   end

   // state register; i_rst is the power-up reset, there is no test-reset pin,
   // and any state reaches reset after five tms-high rises by the graph above
   always_ff @(posedge lnk.tck or posedge i_rst) begin
      if (i_rst) begin
         st_q <= tpp_pkg::TPP_TLR;
      end else begin
         st_q <= st_d;
      end
   end

   // instruction shift stage: capture 01 in the low bits, shift in from tdi
   always_ff @(posedge lnk.tck or posedge i_rst) begin
      if (i_rst) begin
         ir_sh_q <= tpp_pkg::TPP_IR_RESET;
      end else if (st_q == tpp_pkg::TPP_CAP_IR) begin
         ir_sh_q <= {ir_q[2], tpp_pkg::TPP_IR_CAPTURE};
      end else if (st_q == tpp_pkg::TPP_SH_IR) begin
         ir_sh_q <= {lnk.tdi, ir_sh_q[2:1]};
      end
   end

   // instruction register; the ieee rule applies it on the falling edge of
   // update-ir, here it is taken on the rise that leaves update-ir, which
   // is the same point as seen by the next capture
   always_ff @(posedge lnk.tck or posedge i_rst) begin
      if (i_rst) begin
         ir_q <= tpp_pkg::TPP_IR_RESET;
      end else if (st_d == tpp_pkg::TPP_TLR) begin
         // preset on the rise that enters reset, so extest drops at once
         ir_q <= tpp_pkg::TPP_IR_RESET;
      end else if (st_q == tpp_pkg::TPP_UP_IR) begin
         ir_q <= ir_sh_q;
      end
   end

   // register choice by instruction; unknown codes fall back to bypass
   assign sel_bsr = (ir_q == tpp_pkg::TPP_I_EXTEST) || (ir_q == tpp_pkg::TPP_I_SAMPLE);
   assign sel_id = (ir_q == tpp_pkg::TPP_I_IDCODE);
   assign extest_t = (ir_q == tpp_pkg::TPP_I_EXTEST);

   // bypass cell: captures zero, then one tdi bit per rise
   always_ff @(posedge lnk.tck or posedge i_rst) begin
      if (i_rst) begin
         byp_q <= 1'b0;
      end else if (st_q == tpp_pkg::TPP_CAP_DR) begin
         byp_q <= 1'b0;
      end else if (st_q == tpp_pkg::TPP_SH_DR) begin
         byp_q <= lnk.tdi;
      end
   end

   // id register: loads the code in capture-dr, shifts lsb first
   always_ff @(posedge lnk.tck or posedge i_rst) begin
      if (i_rst) begin
         id_q <= tpp_pkg::TPP_IDCODE_VAL;
      end else if (sel_id && st_q == tpp_pkg::TPP_CAP_DR) begin
         id_q <= tpp_pkg::TPP_IDCODE_VAL;
      end else if (sel_id && st_q == tpp_pkg::TPP_SH_DR) begin
         id_q <= {lnk.tdi, id_q[31:1]};
      end
   end

   // pin levels from the core clock: three stages, take a level once the
   // last two agree, so a pin caught mid-change is not half taken
   always_ff @(posedge lnk.tck or posedge i_rst) begin
      if (i_rst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
         pin_q <= '0;
      end else begin
         pin_s1_q <= i_pins;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         // whole word only, so a capture never mixes old and new pin levels
         if (pin_s2_q == pin_s3_q) begin
            pin_q <= pin_s3_q;
         end
      end
   end

   // boundary shift and update stages
   always_ff @(posedge lnk.tck or posedge i_rst) begin
      if (i_rst) begin
         bsr_sh_q <= tpp_pkg::TPP_BSR_RESET;
      end else if (sel_bsr && st_q == tpp_pkg::TPP_CAP_DR) begin
         bsr_sh_q <= pin_q;
      end else if (sel_bsr && st_q == tpp_pkg::TPP_SH_DR) begin
         bsr_sh_q <= {lnk.tdi, bsr_sh_q[W-1:1]};
      end
   end

   always_ff @(posedge lnk.tck or posedge i_rst) begin
      if (i_rst) begin
         bsr_up_q <= tpp_pkg::TPP_BSR_RESET;
      end else if (sel_bsr && st_q == tpp_pkg::TPP_UP_DR) begin
         bsr_up_q <= bsr_sh_q;
      end
   end

   // output end of the register that state and instruction select
   always_comb begin
      ser_out = byp_q;
      if (st_q == tpp_pkg::TPP_SH_IR) begin
         ser_out = ir_sh_q[0];
      end else if (sel_id) begin
         ser_out = id_q[0];
      end else if (sel_bsr) begin
         ser_out = bsr_sh_q[0];
      end
   end

   // tdo launched on the falling edge, driven only in the shift states
   always_ff @(negedge lnk.tck or posedge i_rst) begin
      if (i_rst) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else begin
         tdo_q <= ser_out;
         tdo_oe_q <= (st_q == tpp_pkg::TPP_SH_DR) || (st_q == tpp_pkg::TPP_SH_IR);
      end
   end
   assign lnk.tdo_out = tdo_q;
   assign lnk.tdo_oe = tdo_oe_q;

   // levels into the core clock, three stages; the tck side may stop at any
   // time, so only held levels cross, never events
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= 1'b1;
         rst_s3_q <= 1'b1;
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
         dat_s1_q <= '0;
         dat_s2_q <= '0;
         dat_s3_q <= '0;
      end else begin
         rst_s1_q <= (st_q == tpp_pkg::TPP_TLR);
         rst_s2_q <= rst_s1_q;
         rst_s3_q <= rst_s2_q;
         ext_s1_q <= extest_t;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
         dat_s1_q <= bsr_up_q;
         dat_s2_q <= dat_s1_q;
         dat_s3_q <= dat_s2_q;
      end
   end

   // outputs change once the last two stages agree; a port left idle stays in
   // reset with identification loaded, so the pins are never taken over
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_tap_reset <= 1'b1;
         o_bsr_drive <= 1'b0;
         o_bsr_data <= '0;
      end else begin
         if (rst_s2_q == rst_s3_q) begin
            o_tap_reset <= rst_s3_q;
         end
         if (ext_s2_q == ext_s3_q) begin
            o_bsr_drive <= ext_s3_q;
         end
         // the word is taken whole once two samples agree, never bit by bit
         if (dat_s2_q == dat_s3_q) begin
            o_bsr_data <= dat_s3_q;
         end
      end
   end
endmodule

// ==== core/tpp_host.sv ====
// scan controller end: makes tck from its own clock and runs one tck cycle
// per accepted command, returning the tdo level seen at that cycle's rise
// assumes one command source on i_core_clk; tdo changes only on our tck fall
`timescale 1ns/1ps
module tpp_host (
   tpp_if.host lnk,
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_cmd_valid, // one tck cycle wanted
   input wire logic i_cmd_tms, // tms level for that cycle
   input wire logic i_cmd_tdi, // tdi level for that cycle
   input wire logic i_reset_req, // pulse: run five tms-high cycles
   output logic o_cmd_ready, // command or reset accepted this cycle
   output logic o_rsp_valid, // pulse: sample below is new
   output logic o_rsp_tdo, // tdo seen at the rising edge
   output logic o_rsp_tdo_en // device was driving tdo then
);
   typedef enum logic [1:0] {
      TPH_IDLE = 2'h0, // tck low, waiting
      TPH_LOW = 2'h1, // tck low, tms and tdi settling
      TPH_HIGH = 2'h2 // tck high, device has sampled
   } tpp_host_st_t;
   tpp_host_st_t st_q;
   logic [3:0] half_q; // cycles left in this half period
   logic [2:0] rst_left_q; // tms-high cycles still owed
   logic tck_q, tms_q, tdi_q;
   logic take; // start a new tck cycle

   assign o_cmd_ready = (st_q == TPH_IDLE) && (rst_left_q == 3'h0);
   assign take = (st_q == TPH_IDLE) && (i_cmd_valid || i_reset_req || rst_left_q != 3'h0);

   // tck divider and sequencing; tms and tdi move only while tck is low
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q <= TPH_IDLE;
         half_q <= 4'h0;
         tck_q <= 1'b0;
         tms_q <= 1'b1;
         tdi_q <= 1'b1;
         rst_left_q <= 3'h0;
      end else begin
         case (st_q)
            TPH_IDLE: begin
               if (take) begin
                  st_q <= TPH_LOW;
                  half_q <= 4'(tpp_pkg::TPP_TCK_HALF_CYC - 1);
                  if (i_reset_req && rst_left_q == 3'h0) begin
                     tms_q <= 1'b1;
                     rst_left_q <= 3'(tpp_pkg::TPP_RESET_TMS_CYCLES - 1);
                  end else if (rst_left_q != 3'h0) begin
                     tms_q <= 1'b1;
                     rst_left_q <= rst_left_q - 3'h1;
                  end else begin
                     tms_q <= i_cmd_tms;
                     tdi_q <= i_cmd_tdi;
                  end
               end
            end
            TPH_LOW: begin
               if (half_q == 4'h0) begin
                  st_q <= TPH_HIGH;
                  tck_q <= 1'b1;
                  half_q <= 4'(tpp_pkg::TPP_TCK_HALF_CYC - 1);
               end else begin
                  half_q <= half_q - 4'h1;
               end
            end
            TPH_HIGH: begin
               if (half_q == 4'h0) begin
                  st_q <= TPH_IDLE;
                  tck_q <= 1'b0;
               end else begin
                  half_q <= half_q - 4'h1;
               end
            end
            default: st_q <= TPH_IDLE;
         endcase
      end
   end

   // tdo sampled when tck rises; it was launched on the previous fall of our
   // own tck, so it is settled here and needs no synchroniser
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rsp_valid <= 1'b0;
         o_rsp_tdo <= 1'b0;
         o_rsp_tdo_en <= 1'b0;
      end else begin
         o_rsp_valid <= (st_q == TPH_LOW) && (half_q == 4'h0);
         if ((st_q == TPH_LOW) && (half_q == 4'h0)) begin
            o_rsp_tdo <= lnk.tdo;
            o_rsp_tdo_en <= lnk.tdo_oe;
         end
      end
   end

   assign lnk.tck_out = tck_q;
   assign lnk.tck_oe = 1'b1;
   assign lnk.tms_out = tms_q;
   assign lnk.tms_oe = 1'b1;
   assign lnk.tdi_out = tdi_q;
   assign lnk.tdi_oe = 1'b1;
endmodule

// ==== verification/tap_port_pins_and_reset_bench.sv ====
// bench: host and device joined on one link, a second device worked by hand
// assumes package, interface, both ends and the checker are compiled first
`timescale 1ns/1ps
module tap_port_pins_and_reset_bench;
   `include "tpp_walk.svh"
   logic clk, rst, cmd_valid, cmd_tms, cmd_tdi, reset_req, ready, rsp_valid, rsp_tdo, rsp_en;
   logic tap_reset, bsr_drive, tap_reset_b, bsr_drive_b, seen, ignore_rsp;
   logic [7:0] pins, pins_b, bsr_data, bsr_data_b;
   logic [31:0] r, r2; // random draws
   logic [2:0] note; // {judge tdo, tdo wanted, enable wanted}
   logic [2:0] notes[$]; // one note per command, oldest first
   logic [2:0] ir_now; // instruction the device should hold
   logic [2:0] codes[5] = '{3'h7, 3'h2, 3'h1, 3'h4, 3'h0}; // 3'h2 is unused, reads as bypass
   tpp_pkg::tpp_state_t st; // expected controller state
   integer seed, failures, samples_checked;
   tpp_if lnk();
   tpp_if lnk_b();
   tpp_host u_tpp_host (.lnk(lnk), .i_core_clk(clk), .i_rst(rst), .i_cmd_valid(cmd_valid),
      .i_cmd_tms(cmd_tms), .i_cmd_tdi(cmd_tdi), .i_reset_req(reset_req), .o_cmd_ready(ready),
      .o_rsp_valid(rsp_valid), .o_rsp_tdo(rsp_tdo), .o_rsp_tdo_en(rsp_en));
   tpp_dev u_tpp_dev (.lnk(lnk), .i_core_clk(clk), .i_rst(rst), .i_pins(pins),
      .o_tap_reset(tap_reset), .o_bsr_drive(bsr_drive), .o_bsr_data(bsr_data));
   tpp_dev u_tpp_dev_b (.lnk(lnk_b), .i_core_clk(clk), .i_rst(rst), .i_pins(pins_b),
      .o_tap_reset(tap_reset_b), .o_bsr_drive(bsr_drive_b), .o_bsr_data(bsr_data_b));
   tpp_chk u_tpp_chk (.i_core_clk(clk), .i_rst(rst), .tck(lnk.tck), .tms(lnk.tms),
      .tdi(lnk.tdi), .tdo_out(lnk.tdo_out), .tdo_oe(lnk.tdo_oe));
   // core clock, 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      samples_checked = samples_checked + 1;
      if (got !== want) begin
         failures = failures + 1;
         $display("mismatch at %0t: saw %h, want %h", $time, got, want);
      end
   endtask
   task automatic tally_and_finish();
      if (failures == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // a spent wait bound ends the run as a failure
   task automatic bound(input int n);
      if (n > 400) begin
         failures = failures + 1;
         tally_and_finish();
      end
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n = n + 1;
         bound(n);
      end while (ready !== 1'b1);
   endtask
   // one tck cycle; valid stays up so back-to-back commands never toggle it
   task automatic cyc(input logic m, input logic d, input logic want, input logic judge);
      logic en;
      en = (st == tpp_pkg::TPP_SH_DR) || (st == tpp_pkg::TPP_SH_IR);
      notes.push_back({judge | ~en, en ? want : 1'b1, en}); // undriven tdo reads high
      st = tpp_next(st, m);
      cmd_valid <= 1'b1;
      cmd_tms <= m;
      cmd_tdi <= d;
      wait_ready();
   endtask
   // let the last tck cycle, its answer and the core crossing settle
   task automatic drain();
      int n;
      cmd_valid <= 1'b0;
      repeat (16) @(posedge clk);
      n = 0;
      while (notes.size() != 0) begin
         @(posedge clk);
         n = n + 1;
         bound(n);
      end
   endtask
   // from idle into a shift state, n bits lsb first, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [63:0] din,
      input logic [63:0] want);
      cyc(1'b1, 1'b0, 1'b0, 1'b0);
      if (ir) begin
         cyc(1'b1, 1'b0, 1'b0, 1'b0);
      end
      cyc(1'b0, 1'b0, 1'b0, 1'b0);
      cyc(1'b0, 1'b0, 1'b0, 1'b0);
      for (int i = 0; i < n; i++) begin
         cyc(i == n - 1, din[i], want[i], 1'b1);
      end
      cyc(1'b1, 1'b0, 1'b0, 1'b0);
      cyc(1'b0, 1'b0, 1'b0, 1'b0);
      drain();
   endtask
   // six ir bits: three random pads first, so the pads come back out
   task automatic load_ir(input logic [2:0] code);
      logic [2:0] p;
      r = $random(seed);
      p = r[2:0];
      scan(1'b1, 6, {58'h0, code, p}, {58'h0, p, ir_now[2], tpp_pkg::TPP_IR_CAPTURE});
      ir_now = code;
   endtask
   // hand-made link clock at 64 ns for the second port; tdo seen before the rise
   task automatic tck_b(input logic m, output logic got);
      lnk_b.tms_out = m;
      #32;
      got = lnk_b.tdo;
      lnk_b.tck_out = 1'b1;
      #32;
      lnk_b.tck_out = 1'b0;
   endtask
   // answers are scored against the oldest note
   always @(posedge clk) begin
      if (rsp_valid === 1'b1 && ignore_rsp !== 1'b1) begin
         if (notes.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            note = notes.pop_front();
            check({31'h0, rsp_en}, {31'h0, note[0]});
            if (note[2]) begin
               check({31'h0, rsp_tdo}, {31'h0, note[1]});
            end
         end
      end
   end
   initial begin
      repeat (90000) @(posedge clk);
      failures = failures + 1;
      tally_and_finish();
   end
   initial begin
      seed = 32'h90a20152;
      failures = 0;
      samples_checked = 0;
      {rst, cmd_valid, cmd_tms, cmd_tdi, reset_req, ignore_rsp} = 6'h28;
      pins = 8'h00;
      pins_b = 8'h00;
      st = tpp_pkg::TPP_TLR;
      ir_now = tpp_pkg::TPP_IR_RESET;
      {lnk_b.tck_out, lnk_b.tck_oe, lnk_b.tms_out, lnk_b.tms_oe} = 4'h0;
      {lnk_b.tdi_out, lnk_b.tdi_oe} = 2'h0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      check({31'h0, tap_reset}, 32'h1);
      check({31'h0, bsr_drive}, 32'h0);
      for (int i = 0; i < 6; i++) begin
         r = $random(seed);
         cyc(1'b1, r[0], 1'b0, 1'b0);
      end
      drain();
      check({31'h0, tap_reset}, 32'h1);
      cyc(1'b0, 1'b0, 1'b0, 1'b0);
      drain();
      check({31'h0, tap_reset}, 32'h0);
      r = $random(seed);
      r2 = $random(seed);
      scan(1'b0, 40, {r2, r}, {24'h0, r[7:0], tpp_pkg::TPP_IDCODE_VAL});
      foreach (codes[k]) begin
         r = $random(seed);
         pins <= r[15:8];
         load_ir(codes[k]);
         check({31'h0, bsr_drive}, {31'h0, codes[k] == tpp_pkg::TPP_I_EXTEST});
         r2 = $random(seed);
         if (codes[k] == tpp_pkg::TPP_I_IDCODE) begin
            scan(1'b0, 32, {32'h0, r2}, {32'h0, tpp_pkg::TPP_IDCODE_VAL});
         end else if (codes[k] == tpp_pkg::TPP_I_SAMPLE || codes[k] == tpp_pkg::TPP_I_EXTEST) begin
            scan(1'b0, 8, {32'h0, r2}, {56'h0, pins});
            check({24'h0, bsr_data}, {24'h0, r2[7:0]});
         end else begin
            scan(1'b0, 9, {32'h0, r2}, {55'h0, r2[7:0], 1'b0});
         end
      end
      // into shift-dr, then five high rises from there
      cyc(1'b1, 1'b0, 1'b0, 1'b0);
      cyc(1'b0, 1'b0, 1'b0, 1'b0);
      cyc(1'b0, 1'b0, 1'b0, 1'b0);
      for (int i = 0; i < 5; i++) begin
         cyc(1'b1, 1'b0, 1'b0, 1'b0);
      end
      drain();
      check({31'h0, tap_reset}, 32'h1);
      check({31'h0, bsr_drive}, 32'h0);
      ir_now = tpp_pkg::TPP_IR_RESET;
      cyc(1'b0, 1'b0, 1'b0, 1'b0);
      load_ir(tpp_pkg::TPP_I_BYPASS);
      // host reset sequence; its answers carry no data worth scoring
      ignore_rsp = 1'b1;
      reset_req <= 1'b1;
      cmd_valid <= 1'b1;
      wait_ready();
      reset_req <= 1'b0;
      drain();
      repeat (80) @(posedge clk);
      ignore_rsp = 1'b0;
      st = tpp_pkg::TPP_TLR;
      ir_now = tpp_pkg::TPP_IR_RESET;
      check({31'h0, tap_reset}, 32'h1);
      cyc(1'b0, 1'b0, 1'b0, 1'b0);
      scan(1'b0, 32, 64'h0, {32'h0, tpp_pkg::TPP_IDCODE_VAL});
      // second port: every line floating first, then clocked with tdi floating and tms floating for the first eight rises
      r = $random(seed);
      pins_b <= r[7:0];
      repeat (20) @(posedge clk);
      check({31'h0, tap_reset_b}, 32'h1);
      check({31'h0, lnk_b.tdo_oe}, 32'h0);
      lnk_b.tck_oe = 1'b1;
      for (int i = 0; i < 19; i++) begin
         lnk_b.tms_oe = (i >= 8);
         if (i == 8) begin
            check({31'h0, tap_reset_b}, 32'h1);
         end
         tck_b(1'(19'h00600 >> i), seen);
         if (i >= 13) begin
            check({31'h0, seen}, 32'(6'b111001 >> (i - 13)) & 32'h1);
         end
      end
      {lnk_b.tck_oe, lnk_b.tms_oe} = 2'h0;
      check({31'h0, bsr_drive_b}, 32'h0);
      tally_and_finish();
   end
endmodule

// ==== verification/tpp_chk.sv ====
// link checker: watches the resolved wires and the device drive of tdo
// assumes the host makes tck from i_core_clk and i_rst resets both ends
`timescale 1ns/1ps
module tpp_chk (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo_out,
   input wire logic tdo_oe
);
   `include "tpp_walk.svh"
   tpp_pkg::tpp_state_t st_q; // shadow of the controller state
   logic [2:0] hi_q; // tms-high rises in a row, stops at five
   // shadow walk, so tdo can be judged without peeking into the device
   always_ff @(posedge tck or posedge i_rst) begin
      if (i_rst) begin
         st_q <= tpp_pkg::TPP_TLR;
      end else begin
         st_q <= tpp_next(st_q, tms);
      end
   end
   // run of high tms; saturating keeps the counter small
   always_ff @(posedge tck or posedge i_rst) begin
      if (i_rst) begin
         hi_q <= 3'h0;
      end else if (tms) begin
         hi_q <= (hi_q == 3'h5) ? hi_q : hi_q + 3'h1;
      end else begin
         hi_q <= 3'h0;
      end
   end
   property p_tdo_en;
      @(posedge tck) disable iff (i_rst)
      tdo_oe == (st_q == tpp_pkg::TPP_SH_DR || st_q == tpp_pkg::TPP_SH_IR);
   endproperty
   a_tdo_en: assert property (p_tdo_en) else $error("tdo drive outside shift");
   property p_five_high;
      @(posedge tck) disable iff (i_rst) (hi_q == 3'h5) |-> !tdo_oe;
   endproperty
   a_five_high: assert property (p_five_high) else $error("no reset after tms run");
   property p_cap_ir;
      @(posedge tck) disable iff (i_rst) (st_q == tpp_pkg::TPP_CAP_IR && !tms)
      |=> (tdo_oe && tdo_out) ##1 (!tdo_oe || !tdo_out);
   endproperty
   a_cap_ir: assert property (p_cap_ir) else $error("bad capture pattern");
   sequence s_ir_shift;
      (st_q == tpp_pkg::TPP_SH_IR && !tms) [*3];
   endsequence
   property p_ir_path;
      @(posedge tck) disable iff (i_rst) s_ir_shift |=> tdo_out == $past(tdi, 3);
   endproperty
   a_ir_path: assert property (p_ir_path) else $error("tdi bit lost in ir");
   property p_on_fall;
      @(posedge i_core_clk) disable iff (i_rst)
      ($changed(tdo_oe) || $changed(tdo_out)) |-> $fell(tck);
   endproperty
   a_on_fall: assert property (p_on_fall) else $error("tdo moved off a fall");
   property p_hold_high;
      @(posedge i_core_clk) disable iff (i_rst) tck |-> $stable(tdo_out) && $stable(tdo_oe);
   endproperty
   a_hold_high: assert property (p_hold_high) else $error("tdo moved while tck high");
   property p_tck_high;
      @(posedge i_core_clk) disable iff (i_rst) $rose(tck) |-> tck [*4] ##1 !tck;
   endproperty
   a_tck_high: assert property (p_tck_high) else $error("tck high phase wrong");
   property p_host_hold;
      @(posedge i_core_clk) disable iff (i_rst) tck |-> $stable(tms) && $stable(tdi);
   endproperty
   a_host_hold: assert property (p_host_hold) else $error("tms or tdi moved");
   c_ir: cover property (@(posedge tck) disable iff (i_rst) st_q == tpp_pkg::TPP_SH_IR);
   c_dr: cover property (@(posedge tck) disable iff (i_rst) st_q == tpp_pkg::TPP_SH_DR);
   c_run: cover property (@(posedge tck) disable iff (i_rst) hi_q == 3'h5);
endmodule

// ==== verification/tpp_walk.svh ====
// next-state tables of the test controller, one nibble per state
// assumes tpp_pkg is compiled first; included inside a module body
// no include guard: checker and bench each need their own copy in their body
localparam logic [63:0] TPP_WALK_T0 = 64'h1bddbba146644311; // next state, tms low
localparam logic [63:0] TPP_WALK_T1 = 64'h2fefcc0287855920; // next state, tms high
// one tck rise of the standard graph
function automatic tpp_pkg::tpp_state_t tpp_next(input tpp_pkg::tpp_state_t s, input logic m);
   return tpp_pkg::tpp_state_t'(m ? TPP_WALK_T1[4 * s +: 4] : TPP_WALK_T0[4 * s +: 4]);
endfunction
